/* shared/pmw_defines.svh */
// Timing constants of the mode, wake, time-base and watchdog controller.
`ifndef PMW_DEFINES_SVH
`define PMW_DEFINES_SVH

// ****************************************************************
// Clock rates
// ****************************************************************
`define PMW_REF_CLK_HZ 100000000
`define PMW_SYS_CLK_HZ 4000000
`define PMW_REF_PER_US (`PMW_REF_CLK_HZ / 1000000)
`define PMW_SYS_DIV (`PMW_REF_CLK_HZ / `PMW_SYS_CLK_HZ)
`define PMW_SYS_NS (1000000000 / `PMW_SYS_CLK_HZ)
`define PMW_SLOW_RATIO 16

// ****************************************************************
// Waits, in their own unit and in reference clock cycles
// ****************************************************************
`define PMW_POR_US 131000
`define PMW_POR_CYC (`PMW_POR_US * `PMW_REF_PER_US)
`define PMW_STAB_US 50
`define PMW_STAB_CYC (`PMW_STAB_US * `PMW_REF_PER_US)
`define PMW_WDT_US 28000
`define PMW_WDT_CYC (`PMW_WDT_US * `PMW_REF_PER_US)

// ****************************************************************
// Time-base periods, in ns and in system clock ticks
// ****************************************************************
`define PMW_TB0_NS 64000
`define PMW_TB1_NS 128000
`define PMW_TB2_NS 256000
`define PMW_TB3_NS 1024000
`define PMW_TB0_TICKS (`PMW_TB0_NS / `PMW_SYS_NS)
`define PMW_TB1_TICKS (`PMW_TB1_NS / `PMW_SYS_NS)
`define PMW_TB2_TICKS (`PMW_TB2_NS / `PMW_SYS_NS)
`define PMW_TB3_TICKS (`PMW_TB3_NS / `PMW_SYS_NS)

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define PMW_NUM_PINS 24
`define PMW_DIR_RST 24'h000000
`define PMW_OUT_RST 24'h000000

`endif

/* shared/pmw_pkg.sv */
// Types of the mode, wake, time-base and watchdog controller.
package pmw_pkg;

  typedef enum logic [4:0] {
    st_por    = 5'h01,
    st_normal = 5'h02,
    st_slow   = 5'h04,
    st_halt   = 5'h08,
    st_stab   = 5'h10
  } pmw_mode_e;

  typedef logic [1:0] pmw_tick_sel_t;

endpackage : pmw_pkg

/* shared/pmw_tb_if.sv */
// Link between the mode controller and the time-base generator.
`timescale 1ns/1ns
interface pmw_tb_if;
  logic ce;
  logic clr;
  pmw_pkg::pmw_tick_sel_t sel;
  logic irq_en;
  logic status_rd;
  logic [3:0] status;
  logic irq;

  modport ctrl (output ce, output clr, output sel, output irq_en, output status_rd,
                input status, input irq);
  modport tb (input ce, input clr, input sel, input irq_en, input status_rd,
              output status, output irq);
endinterface : pmw_tb_if

/* src/pmw_ctrl.sv */
// Operating-mode, wake-up, time-base and watchdog controller, top level.
`timescale 1ns/1ns
`include "pmw_defines.svh"

// Summary of operation
// - Normal mode runs 4MHz system clock enable.
// - Hold reset 131ms after power-up, then Normal.
// - Four tick periods; two-bit field picks interrupt.
// - Four-bit status shows all tick periods.
// - Tick interrupt only when enable bit set.
// - Slow instruction gives sixteen-times slower clock.
// - No instruction execution while in Slow.
// - Interrupt or pin change leaves Slow; 50us wait.
// - Halt instruction gates clock, stops time base and watchdog.
// - Only pin change wakes from Halt (external reset also leaves it); 50us wait.
// - Register-controlled pull-high pins wake on falling.
// - Option pull-high pins wake on either edge.
// - Watchdog resets after 28ms unless cleared.
// - Optional external pin resets when low.
// - Each pin has its own direction bit.
module pmw_ctrl #(
  parameter int POR_CYC = `PMW_POR_CYC,
  parameter int WDT_CYC = `PMW_WDT_CYC,
  parameter int STAB_CYC = `PMW_STAB_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Instruction strobes from the sequencer and interrupt request
  input wire logic i_slow_instr,
  input wire logic i_halt_instr,
  input wire logic i_watchdog_clear_instr,
  input wire logic i_irq_req,
  // Time base
  input wire pmw_pkg::pmw_tick_sel_t i_tick_sel,
  input wire logic i_tick_irq_enable,
  input wire logic i_tick_status_rd,
  output logic [3:0] o_tick_status,
  output logic o_tick_irq,
  // Port pins
  input wire logic [`PMW_NUM_PINS-1:0] i_port_pins,
  input wire logic [`PMW_NUM_PINS-1:0] i_port_out,
  input wire logic i_port_dir_wr,
  input wire logic [`PMW_NUM_PINS-1:0] i_port_dir,
  input wire logic [`PMW_NUM_PINS-1:0] i_pull_fixed,
  output logic [`PMW_NUM_PINS-1:0] o_port_pins,
  output logic [`PMW_NUM_PINS-1:0] o_port_pins_oe,
  // External reset option
  input wire logic i_ext_reset_opt,
  input wire logic i_ext_reset_pin_n,
  // System control
  output logic o_sys_rst_n,
  output logic o_sys_clk_en,
  output logic o_cpu_stall,
  output pmw_pkg::pmw_mode_e o_mode
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int DIV_LAST = `PMW_SYS_DIV - 1;
  localparam logic [3:0] SLOW_LAST = 4'(`PMW_SLOW_RATIO - 1);

  pmw_pkg::pmw_mode_e st_q;
  pmw_pkg::pmw_mode_e st_d;
  logic [23:0] wait_q;
  logic [23:0] wait_d;
  logic [21:0] wdt_q;
  logic [21:0] wdt_d;
  logic [4:0] div_q;
  logic [4:0] div_d;
  logic [3:0] sub_q;
  logic [3:0] sub_d;
  logic ce4;
  logic clk_en_q;
  logic clk_en_d;
  logic rst_n_q;
  logic stall_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_rst;
  logic wdt_run;
  logic wdt_expire;
  logic wake;
  logic slow_wake;
  logic [`PMW_NUM_PINS-1:0] dir_q;
  logic [`PMW_NUM_PINS-1:0] dir_d;
  logic [`PMW_NUM_PINS-1:0] out_q;

  pmw_tb_if tb_if ();

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  pmw_wake_det u_wake (
    .i_ref_clk (i_ref_clk),
    .i_rst_n (i_rst_n),
    .i_pins (i_port_pins),
    .i_pull_fixed (i_pull_fixed),
    .o_wake (wake)
  );

  pmw_timebase u_tb (
    .i_ref_clk (i_ref_clk),
    .i_rst_n (i_rst_n),
    .tb (tb_if.tb)
  );

  assign tb_if.ce = clk_en_q;
  assign tb_if.clr = (st_q == pmw_pkg::st_por);
  assign tb_if.sel = i_tick_sel;
  assign tb_if.irq_en = i_tick_irq_enable;
  assign tb_if.status_rd = i_tick_status_rd;

  // ****************************************************************
  // Clock enables
  // ****************************************************************
  always_comb begin
    ce4 = (div_q == 5'(DIV_LAST));
    div_d = ce4 ? 5'h00 : div_q + 5'h01;
    sub_d = ce4 ? sub_q + 4'h1 : sub_q;
    case (st_q)
      pmw_pkg::st_normal: clk_en_d = ce4;
      pmw_pkg::st_slow: clk_en_d = ce4 & (sub_q == SLOW_LAST);
      pmw_pkg::st_halt: clk_en_d = 1'b0;
      default: clk_en_d = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 5'h00;
      sub_q <= 4'h0;
      clk_en_q <= 1'b0;
    end else begin
      div_q <= div_d;
      sub_q <= sub_d;
      clk_en_q <= clk_en_d;
    end
  end

  // ****************************************************************
  // Reset sources and watchdog
  // ****************************************************************
  always_comb begin
    ext_rst = i_ext_reset_opt & ~ext_s2_q;
    wdt_run = (st_q == pmw_pkg::st_normal) || (st_q == pmw_pkg::st_slow);
    wdt_expire = wdt_run && !i_watchdog_clear_instr && (wdt_q == 22'(WDT_CYC - 1));
    if (st_q == pmw_pkg::st_por || i_watchdog_clear_instr) begin
      wdt_d = 22'h000000;
    end else if (wdt_run) begin
      wdt_d = wdt_q + 22'h000001;
    end else begin
      wdt_d = wdt_q;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      wdt_q <= 22'h000000;
    end else begin
      ext_s1_q <= i_ext_reset_pin_n;
      ext_s2_q <= ext_s1_q;
      wdt_q <= wdt_d;
    end
  end

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  always_comb begin
    slow_wake = i_irq_req | tb_if.irq | wake;
    st_d = st_q;
    wait_d = wait_q;
    case (st_q)
      pmw_pkg::st_por: begin
        if (wait_q == 24'(POR_CYC - 1)) begin
          st_d = pmw_pkg::st_normal;
          wait_d = 24'h000000;
        end else begin
          wait_d = wait_q + 24'h000001;
        end
      end
      pmw_pkg::st_normal: begin
        if (i_halt_instr) begin
          st_d = pmw_pkg::st_halt;
        end else if (i_slow_instr) begin
          st_d = pmw_pkg::st_slow;
        end
      end
      pmw_pkg::st_slow: begin
        if (slow_wake) begin
          st_d = pmw_pkg::st_stab;
          wait_d = 24'h000000;
        end
      end
      pmw_pkg::st_halt: begin
        if (wake) begin
          st_d = pmw_pkg::st_stab;
          wait_d = 24'h000000;
        end
      end
      pmw_pkg::st_stab: begin
        if (wait_q == 24'(STAB_CYC - 1)) begin
          st_d = pmw_pkg::st_normal;
          wait_d = 24'h000000;
        end else begin
          wait_d = wait_q + 24'h000001;
        end
      end
      default: begin
        st_d = pmw_pkg::st_por;
        wait_d = 24'h000000;
      end
    endcase
    if (ext_rst || wdt_expire) begin
      st_d = pmw_pkg::st_por;
      wait_d = 24'h000000;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= pmw_pkg::st_por;
      wait_q <= 24'h000000;
      rst_n_q <= 1'b0;
      stall_q <= 1'b1;
    end else begin
      st_q <= st_d;
      wait_q <= wait_d;
      rst_n_q <= (st_d != pmw_pkg::st_por);
      stall_q <= (st_d != pmw_pkg::st_normal);
    end
  end

  // ****************************************************************
  // Pin direction and output data
  // ****************************************************************
  always_comb begin
    dir_d = i_port_dir_wr ? i_port_dir : dir_q;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_q <= `PMW_DIR_RST;
      out_q <= `PMW_OUT_RST;
    end else begin
      dir_q <= dir_d;
      out_q <= i_port_out;
    end
  end

  assign o_port_pins = out_q;
  assign o_port_pins_oe = dir_q;
  assign o_tick_status = tb_if.status;
  assign o_tick_irq = tb_if.irq;
  assign o_sys_rst_n = rst_n_q;
  assign o_sys_clk_en = clk_en_q;
  assign o_cpu_stall = stall_q;
  assign o_mode = st_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  localparam int NORM_GAP = `PMW_SYS_DIV;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  chk_normal_rate: assert property ((clk_en_q && $past(st_q) == pmw_pkg::st_normal)
      |-> ##NORM_GAP (clk_en_q || $past(st_q) != pmw_pkg::st_normal))
    else $error("Normal clock enable not at 4MHz.");
  chk_por_release: assert property ($rose(o_sys_rst_n)
      |-> $past(wait_q) == 24'(POR_CYC - 1) && o_mode == pmw_pkg::st_normal)
    else $error("Reset released before power-on wait.");
  chk_slow_rate: assert property ((clk_en_q && $past(st_q) == pmw_pkg::st_slow)
      |-> $past(sub_q) == SLOW_LAST && $past(ce4))
    else $error("Slow clock enable not one in sixteen.");
  chk_slow_stall: assert property ((st_q == pmw_pkg::st_slow) |-> o_cpu_stall)
    else $error("Execution not stalled in Slow.");
  chk_slow_wake: assert property ((st_q == pmw_pkg::st_slow && slow_wake
      && !ext_rst && !wdt_expire) |=> st_q == pmw_pkg::st_stab)
    else $error("Slow mode did not wake.");
  chk_halt_gate: assert property ((st_q == pmw_pkg::st_halt) |=> !clk_en_q)
    else $error("Clock enable running in Halt.");
  chk_halt_hold: assert property ((st_q == pmw_pkg::st_halt && !wake && !ext_rst)
      |=> st_q == pmw_pkg::st_halt)
    else $error("Halt left without pin change.");
  chk_wdt_reset: assert property (wdt_expire |=> st_q == pmw_pkg::st_por
      && !o_sys_rst_n)
    else $error("Watchdog timeout did not reset.");
  chk_ext_reset: assert property (ext_rst |=> st_q == pmw_pkg::st_por
      && !o_sys_rst_n)
    else $error("External reset pin ignored.");
  chk_dir_write: assert property (i_port_dir_wr
      |=> o_port_pins_oe == $past(i_port_dir))
    else $error("Direction write not applied.");
  chk_stab_return: assert property ((st_q == pmw_pkg::st_stab
      && wait_q == 24'(STAB_CYC - 1) && !ext_rst && !wdt_expire)
      |=> st_q == pmw_pkg::st_normal && !o_cpu_stall)
    else $error("No return to Normal after wake wait.");

  cov_slow_wake: cover property (st_q == pmw_pkg::st_slow ##1 st_q == pmw_pkg::st_stab);
  cov_halt_wake: cover property (st_q == pmw_pkg::st_halt ##1 st_q == pmw_pkg::st_stab);
  cov_wdt_reset: cover property (wdt_expire);
  cov_ext_reset: cover property (ext_rst && st_q == pmw_pkg::st_normal);

endmodule : pmw_ctrl

/* src/pmw_timebase.sv */
// Time-base tick generator with sticky status and interrupt.
`timescale 1ns/1ns
`include "pmw_defines.svh"
module pmw_timebase (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Controller link
  pmw_tb_if.tb tb
);

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic [3:0] hit;
  logic [3:0] status_q;
  logic [3:0] status_d;
  logic irq_q;
  logic irq_d;

  function automatic logic tb_hit(input logic [11:0] c, input logic [12:0] p);
    logic [12:0] n;
    n = {1'b0, c} + 13'h1;
    return (n & (p - 13'h1)) == 13'h0;
  endfunction : tb_hit

  always_comb begin
    hit[0] = tb.ce & tb_hit(cnt_q, 13'(`PMW_TB0_TICKS));
    hit[1] = tb.ce & tb_hit(cnt_q, 13'(`PMW_TB1_TICKS));
    hit[2] = tb.ce & tb_hit(cnt_q, 13'(`PMW_TB2_TICKS));
    hit[3] = tb.ce & tb_hit(cnt_q, 13'(`PMW_TB3_TICKS));
    cnt_d = tb.clr ? 12'h000 : (tb.ce ? cnt_q + 12'h001 : cnt_q);
    status_d = tb.clr ? 4'h0 : ((status_q & ~{4{tb.status_rd}}) | hit);
    irq_d = ~tb.clr & tb.irq_en & hit[tb.sel];
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 12'h000;
      status_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  assign tb.status = status_q;
  assign tb.irq = irq_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  chk_tick_select: assert property (tb.irq |-> $past(hit[tb.sel]))
    else $error("Tick interrupt from an unselected period.");
  chk_status_set: assert property ((hit[0] && !tb.clr) |=> tb.status[0])
    else $error("Status bit not set on period.");
  chk_irq_enable: assert property (tb.irq |-> $past(tb.irq_en))
    else $error("Tick interrupt while disabled.");
  cov_tick_irq: cover property (tb.irq);

endmodule : pmw_timebase

/* src/pmw_wake_det.sv */
// Pin synchroniser and level-change wake-up detector.
`timescale 1ns/1ns
`include "pmw_defines.svh"
module pmw_wake_det (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Pins
  input wire logic [`PMW_NUM_PINS-1:0] i_pins,
  input wire logic [`PMW_NUM_PINS-1:0] i_pull_fixed,
  // Wake event
  output logic o_wake
);

  logic [`PMW_NUM_PINS-1:0] s1_q;
  logic [`PMW_NUM_PINS-1:0] s2_q;
  logic [`PMW_NUM_PINS-1:0] prev_q;
  logic [`PMW_NUM_PINS-1:0] fall;
  logic [`PMW_NUM_PINS-1:0] rise;
  logic wake_d;
  logic wake_q;

  always_comb begin
    fall = prev_q & ~s2_q;
    rise = ~prev_q & s2_q & i_pull_fixed;
    wake_d = (|fall) | (|rise);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      prev_q <= '1;
      wake_q <= 1'b0;
    end else begin
      s1_q <= i_pins;
      s2_q <= s1_q;
      prev_q <= s2_q;
      wake_q <= wake_d;
    end
  end

  assign o_wake = wake_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  chk_fall_wake: assert property ((|fall) |=> o_wake)
    else $error("Falling edge did not wake.");
  chk_rise_gate: assert property (o_wake |-> $past(|(prev_q & ~s2_q))
      || $past(|(~prev_q & s2_q & i_pull_fixed)))
    else $error("Wake without a qualifying edge.");

endmodule : pmw_wake_det

/* verification/pmw_testbench.sv */
// Self-checking bench for the mode, wake, time-base and watchdog controller.
`timescale 1ns/1ns
`include "pmw_defines.svh"
module testbench;
  // ****************************************************************
  // Stimulus, observation and bookkeeping
  // ****************************************************************
  localparam int POR = 200;
  localparam int WDT = 1000;
  localparam int STAB = 20;
  logic i_ref_clk = 1'b0;
  logic i_rst_n, i_slow_instr, i_halt_instr, i_watchdog_clear_instr, i_irq_req;
  pmw_pkg::pmw_tick_sel_t i_tick_sel;
  logic i_tick_irq_enable, i_tick_status_rd, i_port_dir_wr, i_ext_reset_opt, i_ext_reset_pin_n;
  logic [`PMW_NUM_PINS-1:0] i_port_pins, i_port_out, i_port_dir, i_pull_fixed;
  logic [3:0] o_tick_status;
  logic o_tick_irq, o_sys_rst_n, o_sys_clk_en, o_cpu_stall;
  logic [`PMW_NUM_PINS-1:0] o_port_pins, o_port_pins_oe;
  pmw_pkg::pmw_mode_e o_mode;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int en_cnt = 0;
  int irq_cnt = 0;
  int last_irq = 0;
  bit kick = 1'b1;
  pmw_pkg::pmw_mode_e last_mode = pmw_pkg::st_por;
  pmw_pkg::pmw_mode_e mode_q[$];
  int gap_q[$];

  pmw_ctrl #(.POR_CYC(POR), .WDT_CYC(WDT), .STAB_CYC(STAB)) pmw_ctrl_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_slow_instr(i_slow_instr),
    .i_halt_instr(i_halt_instr), .i_watchdog_clear_instr(i_watchdog_clear_instr),
    .i_irq_req(i_irq_req), .i_tick_sel(i_tick_sel), .i_tick_irq_enable(i_tick_irq_enable),
    .i_tick_status_rd(i_tick_status_rd), .o_tick_status(o_tick_status),
    .o_tick_irq(o_tick_irq), .i_port_pins(i_port_pins), .i_port_out(i_port_out),
    .i_port_dir_wr(i_port_dir_wr), .i_port_dir(i_port_dir), .i_pull_fixed(i_pull_fixed),
    .o_port_pins(o_port_pins), .o_port_pins_oe(o_port_pins_oe),
    .i_ext_reset_opt(i_ext_reset_opt), .i_ext_reset_pin_n(i_ext_reset_pin_n),
    .o_sys_rst_n(o_sys_rst_n), .o_sys_clk_en(o_sys_clk_en), .o_cpu_stall(o_cpu_stall),
    .o_mode(o_mode)
  );

  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : step

  task automatic wait_mode(input pmw_pkg::pmw_mode_e m, input int lim, output int n);
    n = 0;
    while (o_mode !== m && n < lim) begin
      step(1);
      n++;
    end
    chk("mode reached", m, o_mode);
  endtask : wait_mode

  task automatic wait_irq(input int lim);
    int n0;
    int k;
    n0 = irq_cnt;
    k = 0;
    while (irq_cnt == n0 && k < lim) begin
      step(1);
      k++;
    end
    chk("tick irq count", n0 + 1, irq_cnt);
  endtask : wait_irq

  task automatic clk_gap(input int exp);
    int n;
    n = 0;
    while (o_sys_clk_en !== 1'b1 && n < 500) begin
      step(1);
      n++;
    end
    n = 0;
    do begin
      step(1);
      n++;
    end while (o_sys_clk_en !== 1'b1 && n < 500);
    chk("clock enable gap", exp, n);
  endtask : clk_gap

  task automatic enter(input bit halt, input pmw_pkg::pmw_mode_e m);
    i_halt_instr = halt;
    i_slow_instr = 1'b1;
    mode_q.push_back(m);
    step(1);
    i_halt_instr = 1'b0;
    i_slow_instr = 1'b0;
    step(2);
    chk("cpu stall", 1, o_cpu_stall);
  endtask : enter

  task automatic expect_wake();
    int n;
    mode_q.push_back(pmw_pkg::st_stab);
    mode_q.push_back(pmw_pkg::st_normal);
    wait_mode(pmw_pkg::st_stab, 20, n);
    wait_mode(pmw_pkg::st_normal, STAB + 5, n);
    chk("stabilisation cycles", STAB, n);
    chk("cpu stall", 0, o_cpu_stall);
  endtask : expect_wake

  // ****************************************************************
  // Output monitor and watchdog servicing
  // ****************************************************************
  always @(posedge i_ref_clk) cyc <= cyc + 1;

  always @(negedge i_ref_clk) begin
    if (o_sys_clk_en === 1'b1) en_cnt++;
    if (o_tick_irq === 1'b1) begin
      irq_cnt++;
      if (gap_q.size() > 0) chk("tick gap", gap_q.pop_front(), cyc - last_irq);
      last_irq = cyc;
    end
    if (o_mode !== last_mode) begin
      if (mode_q.size() > 0) chk("mode", mode_q.pop_front(), o_mode);
      else chk("mode", last_mode, o_mode);
      last_mode = o_mode;
    end
  end

  initial begin
    i_watchdog_clear_instr = 1'b0;
    forever begin
      repeat (300) @(posedge i_ref_clk);
      #1 i_watchdog_clear_instr = kick & o_sys_rst_n;
      @(posedge i_ref_clk);
      #1 i_watchdog_clear_instr = 1'b0;
    end
  end

  initial begin
    repeat (90000) @(posedge i_ref_clk);
    err_total++;
    $display("wrong value run time expected done seen hang");
    tally_and_finish();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int n, e, a, b;
    logic [31:0] d, o;
    {i_rst_n, i_slow_instr, i_halt_instr, i_irq_req, i_tick_irq_enable} = 5'h00;
    {i_tick_status_rd, i_port_dir_wr, i_ext_reset_opt} = 3'h0;
    i_tick_sel = 2'h0;
    i_ext_reset_pin_n = 1'b1;
    i_port_pins = '1;
    i_port_out = '0;
    i_port_dir = '0;
    void'($urandom(32'h8ed7));
    i_pull_fixed = $urandom;
    a = $urandom_range(11, 0);
    b = 12 + $urandom_range(11, 0);
    i_pull_fixed[a] = 1'b0;
    i_pull_fixed[b] = 1'b1;
    repeat (16) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
    mode_q.push_back(pmw_pkg::st_normal);
    wait_mode(pmw_pkg::st_normal, POR + 10, n);
    chk("power-on cycles", POR, n);
    chk("system reset", 1, o_sys_rst_n);
    d = $urandom;
    o = $urandom;
    i_port_dir = d[23:0];
    i_port_out = o[23:0];
    i_port_dir_wr = 1'b1;
    step(1);
    i_port_dir_wr = 1'b0;
    i_port_dir = ~d[23:0];
    chk("pin drive enables", d[23:0], o_port_pins_oe);
    chk("pin data", o[23:0], o_port_pins);
    step(3);
    chk("pin drive enables held", d[23:0], o_port_pins_oe);
    clk_gap(25);
    i_ext_reset_pin_n = 1'b0;
    step(20);
    i_ext_reset_pin_n = 1'b1;
    chk("system reset", 1, o_sys_rst_n);
    i_tick_irq_enable = 1'b1;
    wait_irq(7000);
    gap_q.push_back(256 * 25);
    wait_irq(7000);
    i_tick_status_rd = 1'b1;
    step(1);
    i_tick_status_rd = 1'b0;
    step(1);
    chk("tick status cleared", 0, o_tick_status);
    i_tick_sel = 2'h1;
    wait_irq(13000);
    chk("tick status low pair", 2'h3, o_tick_status[1:0]);
    gap_q.push_back(512 * 25);
    wait_irq(13000);
    i_tick_sel = 2'h2;
    gap_q.push_back(512 * 25);
    wait_irq(13000);
    i_tick_sel = 2'h3;
    n = irq_cnt;
    step(13000);
    chk("tick irq longest period", n, irq_cnt);
    i_tick_sel = 2'h0;
    i_tick_irq_enable = 1'b0;
    step(7000);
    chk("tick irq while disabled", n, irq_cnt);
    i_port_pins[a] = 1'b0;
    i_port_pins[b] = 1'b0;
    step(8);
    enter(1'b1, pmw_pkg::st_halt);
    e = en_cnt;
    i_irq_req = 1'b1;
    i_port_pins[a] = 1'b1;
    step(30);
    i_irq_req = 1'b0;
    chk("clock enables in halt", e, en_cnt);
    i_port_pins[a] = 1'b0;
    expect_wake();
    enter(1'b1, pmw_pkg::st_halt);
    i_port_pins[b] = 1'b1;
    expect_wake();
    enter(1'b0, pmw_pkg::st_slow);
    clk_gap(25 * 16);
    i_irq_req = 1'b1;
    expect_wake();
    i_irq_req = 1'b0;
    kick = 1'b0;
    mode_q.push_back(pmw_pkg::st_por);
    mode_q.push_back(pmw_pkg::st_normal);
    wait_mode(pmw_pkg::st_por, WDT + 350, n);
    chk("system reset", 0, o_sys_rst_n);
    wait_mode(pmw_pkg::st_normal, POR + 10, n);
    chk("power-on cycles", POR, n);
    kick = 1'b1;
    i_ext_reset_opt = 1'b1;
    i_ext_reset_pin_n = 1'b0;
    mode_q.push_back(pmw_pkg::st_por);
    wait_mode(pmw_pkg::st_por, 10, n);
    step(POR + 20);
    chk("mode held in reset", pmw_pkg::st_por, o_mode);
    i_ext_reset_pin_n = 1'b1;
    mode_q.push_back(pmw_pkg::st_normal);
    wait_mode(pmw_pkg::st_normal, POR + 10, n);
    tally_and_finish();
  end
endmodule : testbench
